/* core/csdec_consts.svh */
// Register indexes, field positions and reset values of the chip-select decoder
`ifndef CSDEC_CONSTS_SVH
`define CSDEC_CONSTS_SVH

// Register indexes; the APB byte address is four times the index
`define CSDEC_IDX_BASE0 10'h080
`define CSDEC_IDX_MASK0 10'h084
`define CSDEC_IDX_CTRL0 10'h08a
`define CSDEC_IDX_BASE1 10'h08c
`define CSDEC_IDX_MASK1 10'h090
`define CSDEC_IDX_CTRL1 10'h096
`define CSDEC_IDX_SHARED 10'h098
`define CSDEC_IDX_MASK2 10'h09c
`define CSDEC_IDX_CTRL2 10'h0a2
`define CSDEC_IDX_MASK3 10'h0aa
`define CSDEC_IDX_CTRL3 10'h0ae
`define CSDEC_IDX_MASK4 10'h0b6
`define CSDEC_IDX_CTRL4 10'h0ba
`define CSDEC_IDX_MASK5 10'h0c2
`define CSDEC_IDX_CTRL5 10'h0c6
`define CSDEC_IDX_MASK6 10'h0ce
`define CSDEC_IDX_CTRL6 10'h0d2
`define CSDEC_IDX_MASK7 10'h0da
`define CSDEC_IDX_CTRL7 10'h0de

// Mask register fields
`define CSDEC_MASK_VALID 0
`define CSDEC_MASK_CPU 8
`define CSDEC_MASK_WR_LOW 32'hffff0101
`define CSDEC_MASK_WR_MID 32'h00000001
`define CSDEC_MASK_WR_TOP 32'h00000101

// Control register fields
`define CSDEC_CTRL_WS_HI 13
`define CSDEC_CTRL_WS_LO 10
`define CSDEC_CTRL_AA 8
`define CSDEC_CTRL_PS_HI 7
`define CSDEC_CTRL_PS_LO 6
`define CSDEC_CTRL_BEM 5
`define CSDEC_CTRL_BSTR 4
`define CSDEC_CTRL_BSTW 3
`define CSDEC_CTRL_WR 16'h3df8
`define CSDEC_CTRL0_RESET 16'h3c20

// Banks two to seven decode 2 MB blocks above the shared base
`define CSDEC_UPPER_BLOCK_LSB 21

`endif

/* core/csdec_pkg.sv */
// Types shared by the chip-select decoder
package csdec_pkg;

    typedef enum logic [1:0] {
        CSDEC_W32 = 2'h0,
        CSDEC_W8 = 2'h1,
        CSDEC_W16 = 2'h2
    } csdec_width_t;

    typedef enum logic [1:0] {
        CSDEC_BYTE = 2'h0,
        CSDEC_WORD = 2'h1,
        CSDEC_LONG = 2'h2,
        CSDEC_LINE = 2'h3
    } csdec_size_t;

endpackage

/* core/csdec_lane_decode.sv */
// Byte lane decode from port width, transfer size and low address bits
`timescale 1ns/100ps
module csdec_lane_decode (
    // Cycle description
    input wire csdec_pkg::csdec_width_t width,
    input wire csdec_pkg::csdec_size_t size,
    input wire logic [1:0] addr_lo,
    // Active-low lanes, lane 0 is data bits 31:24
    output logic [3:0] lane_n
);
    import csdec_pkg::*;

    always_comb begin
        lane_n = 4'hf;
        unique case (size)
            CSDEC_BYTE: begin
                unique case (width)
                    CSDEC_W8: lane_n = 4'he;
                    CSDEC_W16: lane_n = addr_lo[0] ? 4'hd : 4'he;
                    default: lane_n = ~(4'h1 << addr_lo);
                endcase
            end
            CSDEC_WORD: begin
                unique case (width)
                    CSDEC_W8: lane_n = 4'he;
                    CSDEC_W16: lane_n = 4'hc;
                    default: lane_n = addr_lo[1] ? 4'h3 : 4'hc;
                endcase
            end
            default: begin
                unique case (width)
                    CSDEC_W8: lane_n = 4'he;
                    CSDEC_W16: lane_n = 4'hc;
                    default: lane_n = 4'h0;
                endcase
            end
        endcase
    end

endmodule

/* core/csdec_top.sv */
// Chip-select decoder: APB registers, bank compare and cycle attribute outputs
// How it works
// - Every bank has mask and control register
// - Banks 0,1: 16-bit base, 32-bit mask
// - Banks 2-7 share one 8-bit base
// - Upper banks decode fixed 2 MB blocks
// - Control sets width, burst, waits, auto-ack
// - Bank 0 global select after reset
// - Banks 0,1,7 may match processor-space cycles
// - Every access compared against all banks
// - No match: external, burst-off, 32-bit cycle
// - Multiple match: all selects, external 32-bit
// - Single match: use that bank's control
// - Static sizing from port width field
// - Word transfer lane pattern per width
// - Longword and line lane pattern per width
// - Reset disables banks, bank 0 strapped
// - Global bank 0 until valid bit set
// - Strap bits 6:5 choose boot width
// - Read enable only on match, falling edge
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "csdec_consts.svh"
module csdec_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Access from the processor core
    input wire logic acc_active,
    input wire logic [31:0] acc_addr,
    input wire csdec_pkg::csdec_size_t acc_size,
    input wire logic acc_write,
    input wire logic acc_cpu_space,
    // Data bus levels seen during reset
    input wire logic [7:0] strap_data,
    // External memory side
    output logic [7:0] bank_select_n,
    output logic [3:0] lane_write_strobe_n,
    output logic read_enable_n,
    // Cycle attributes for the bus controller
    output csdec_pkg::csdec_width_t cycle_port_width,
    output logic cycle_burst_ok,
    output logic cycle_ext_term,
    output logic cycle_auto_ack,
    output logic [3:0] cycle_wait_states,
    output logic cycle_multi_match
);
    import csdec_pkg::*;

    localparam logic [9:0] MASK_IDX [8] = '{`CSDEC_IDX_MASK0, `CSDEC_IDX_MASK1, `CSDEC_IDX_MASK2,
        `CSDEC_IDX_MASK3, `CSDEC_IDX_MASK4, `CSDEC_IDX_MASK5, `CSDEC_IDX_MASK6, `CSDEC_IDX_MASK7};
    localparam logic [9:0] CTRL_IDX [8] = '{`CSDEC_IDX_CTRL0, `CSDEC_IDX_CTRL1, `CSDEC_IDX_CTRL2,
        `CSDEC_IDX_CTRL3, `CSDEC_IDX_CTRL4, `CSDEC_IDX_CTRL5, `CSDEC_IDX_CTRL6, `CSDEC_IDX_CTRL7};
    localparam logic [31:0] MASK_WR [8] = '{`CSDEC_MASK_WR_LOW, `CSDEC_MASK_WR_LOW, `CSDEC_MASK_WR_MID,
        `CSDEC_MASK_WR_MID, `CSDEC_MASK_WR_MID, `CSDEC_MASK_WR_MID, `CSDEC_MASK_WR_MID, `CSDEC_MASK_WR_TOP};

    logic [15:0] bank_base_reg [2];
    logic [7:0] shared_upper_bank_base_reg;
    logic [31:0] bank_mask_reg [8];
    logic [15:0] bank_control_reg [8];
    logic [2:0] strap_q1;
    logic [2:0] strap_q2;
    logic strap_done;
    logic [9:0] reg_idx;
    logic apb_write;
    logic reg_hit;
    logic boot_valid;
    logic [7:0] match;
    logic [3:0] match_count;
    logic [15:0] sel_ctrl;
    csdec_width_t sel_width;
    csdec_width_t next_width;
    logic [3:0] lane_n;
    logic acc_write_q;

    function automatic csdec_width_t width_of(input logic [1:0] ps);
        unique case (ps)
            2'h0: width_of = CSDEC_W32;
            2'h1: width_of = CSDEC_W8;
            default: width_of = CSDEC_W16;
        endcase
    endfunction

    // APB slave: zero wait states, error on unmapped index
    assign reg_idx = paddr[11:2];
    assign apb_write = psel & penable & pwrite & reg_hit;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~reg_hit;

    always_comb begin
        reg_hit = (reg_idx == `CSDEC_IDX_BASE0) || (reg_idx == `CSDEC_IDX_BASE1) ||
            (reg_idx == `CSDEC_IDX_SHARED);
        prdata = 32'h0;
        if (reg_idx == `CSDEC_IDX_BASE0) begin
            prdata = {16'h0, bank_base_reg[0]};
        end
        if (reg_idx == `CSDEC_IDX_BASE1) begin
            prdata = {16'h0, bank_base_reg[1]};
        end
        if (reg_idx == `CSDEC_IDX_SHARED) begin
            prdata = {24'h0, shared_upper_bank_base_reg};
        end
        for (int i = 0; i < 8; i++) begin
            if (reg_idx == MASK_IDX[i]) begin
                reg_hit = 1'b1;
                prdata = bank_mask_reg[i];
            end
            if (reg_idx == CTRL_IDX[i]) begin
                reg_hit = 1'b1;
                prdata = {16'h0, bank_control_reg[i]};
            end
        end
    end

    // Base registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_base_reg[0] <= 16'h0;
            bank_base_reg[1] <= 16'h0;
            shared_upper_bank_base_reg <= 8'h0;
        end else if (apb_write) begin
            if (reg_idx == `CSDEC_IDX_BASE0) begin
                bank_base_reg[0] <= pwdata[15:0];
            end
            if (reg_idx == `CSDEC_IDX_BASE1) begin
                bank_base_reg[1] <= pwdata[15:0];
            end
            if (reg_idx == `CSDEC_IDX_SHARED) begin
                shared_upper_bank_base_reg <= pwdata[7:0];
            end
        end
    end

    // Strap synchroniser runs through reset so pin levels are ready at release
    always_ff @(posedge pclk) begin
        strap_q1 <= strap_data[7:5];
        strap_q2 <= strap_q1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= 1'b1;
        end
    end

    // Mask and control registers, one pair per bank
    generate
        for (genvar g = 0; g < 8; g++) begin : g_bank_regs
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bank_mask_reg[g] <= 32'h0;
                end else if (apb_write && reg_idx == MASK_IDX[g]) begin
                    bank_mask_reg[g] <= pwdata & MASK_WR[g];
                end
            end
            if (g == 0) begin : g_boot_ctrl
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        bank_control_reg[g] <= `CSDEC_CTRL0_RESET;
                    end else if (!strap_done) begin
                        bank_control_reg[g][`CSDEC_CTRL_AA] <= strap_q2[2];
                        bank_control_reg[g][`CSDEC_CTRL_PS_HI:`CSDEC_CTRL_PS_LO] <= strap_q2[1:0];
                    end else if (apb_write && reg_idx == CTRL_IDX[g]) begin
                        bank_control_reg[g] <= pwdata[15:0] & `CSDEC_CTRL_WR;
                    end
                end
            end else begin : g_ctrl
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        bank_control_reg[g] <= 16'h0;
                    end else if (apb_write && reg_idx == CTRL_IDX[g]) begin
                        bank_control_reg[g] <= pwdata[15:0] & `CSDEC_CTRL_WR;
                    end
                end
            end
        end
    endgenerate

    // Bank compare
    assign boot_valid = bank_mask_reg[0][`CSDEC_MASK_VALID];

    generate
        for (genvar g = 0; g < 8; g++) begin : g_match
            logic addr_hit;
            logic bank_on;
            if (g < 2) begin : g_low
                assign addr_hit = ((acc_addr[31:16] ^ bank_base_reg[g]) & ~bank_mask_reg[g][31:16]) == 16'h0;
            end else begin : g_up
                assign addr_hit = (acc_addr[31:24] == shared_upper_bank_base_reg) &&
                    (acc_addr[23:`CSDEC_UPPER_BLOCK_LSB] == 3'(g - 2));
            end
            assign bank_on = bank_mask_reg[g][`CSDEC_MASK_VALID] && (g == 0 || boot_valid);
            if (g == 0) begin : g_global
                assign match[g] = acc_active && (!bank_on ||
                    (acc_cpu_space ? bank_mask_reg[g][`CSDEC_MASK_CPU] : addr_hit));
            end else begin : g_normal
                assign match[g] = acc_active && bank_on &&
                    (acc_cpu_space ? bank_mask_reg[g][`CSDEC_MASK_CPU] : addr_hit);
            end
        end
    endgenerate

    always_comb begin
        match_count = 4'h0;
        sel_ctrl = 16'h0;
        for (int i = 0; i < 8; i++) begin
            match_count = match_count + {3'h0, match[i]};
            if (match[i]) begin
                sel_ctrl = sel_ctrl | bank_control_reg[i];
            end
        end
    end

    assign sel_width = width_of(sel_ctrl[`CSDEC_CTRL_PS_HI:`CSDEC_CTRL_PS_LO]);
    assign next_width = (match_count == 4'h1) ? sel_width : CSDEC_W32;

    csdec_lane_decode csdec_lane_decode_inst (
        .width(next_width),
        .size(acc_size),
        .addr_lo(acc_addr[1:0]),
        .lane_n(lane_n)
    );

    // Cycle outputs, one clock after the access is presented
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_n <= 8'hff;
            lane_write_strobe_n <= 4'hf;
            cycle_port_width <= CSDEC_W32;
            cycle_burst_ok <= 1'b0;
            cycle_ext_term <= 1'b1;
            cycle_auto_ack <= 1'b0;
            cycle_wait_states <= 4'h0;
            cycle_multi_match <= 1'b0;
        end else begin
            bank_select_n <= ~match;
            lane_write_strobe_n <= 4'hf;
            if (acc_active && (acc_write || (match_count == 4'h1 && sel_ctrl[`CSDEC_CTRL_BEM]))) begin
                lane_write_strobe_n <= lane_n;
            end
            cycle_port_width <= next_width;
            cycle_multi_match <= match_count > 4'h1;
            if (match_count == 4'h1) begin
                cycle_burst_ok <= acc_write ? sel_ctrl[`CSDEC_CTRL_BSTW] : sel_ctrl[`CSDEC_CTRL_BSTR];
                cycle_ext_term <= ~sel_ctrl[`CSDEC_CTRL_AA];
                cycle_auto_ack <= sel_ctrl[`CSDEC_CTRL_AA];
                cycle_wait_states <= sel_ctrl[`CSDEC_CTRL_WS_HI:`CSDEC_CTRL_WS_LO];
            end else begin
                cycle_burst_ok <= 1'b0;
                cycle_ext_term <= 1'b1;
                cycle_auto_ack <= 1'b0;
                cycle_wait_states <= 4'h0;
            end
        end
    end

    // Read enable moves on the falling edge from the registered selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_write_q <= 1'b0;
        end else begin
            acc_write_q <= acc_write;
        end
    end

    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_enable_n <= 1'b1;
        end else begin
            read_enable_n <= ~((bank_select_n != 8'hff) && !acc_write_q);
        end
    end

    a_no_match_ext: assert property (@(posedge pclk) disable iff (!presetn)
        acc_active && match == 8'h0 |=> cycle_ext_term && !cycle_burst_ok && cycle_port_width == CSDEC_W32)
        else $error("no-match cycle not external 32-bit");
    a_multi_all_selects: assert property (@(posedge pclk) disable iff (!presetn)
        match_count > 4'h1 |=> bank_select_n == ~$past(match) && cycle_ext_term && cycle_multi_match)
        else $error("multiple match handled wrongly");
    a_single_bank_width: assert property (@(posedge pclk) disable iff (!presetn)
        match_count == 4'h1 |=> cycle_port_width == $past(sel_width) && cycle_auto_ack == !cycle_ext_term)
        else $error("single match did not use bank control");
    a_global_boot_bank: assert property (@(posedge pclk) disable iff (!presetn)
        acc_active && !boot_valid |=> !bank_select_n[0] && bank_select_n[7:1] == 7'h7f)
        else $error("global bank 0 not selected alone");
    a_upper_block_hit: assert property (@(posedge pclk) disable iff (!presetn)
        acc_active && !acc_cpu_space && boot_valid && bank_mask_reg[2][0] &&
        acc_addr[31:21] == {shared_upper_bank_base_reg, 3'h0} |=> !bank_select_n[2])
        else $error("bank 2 missed its 2 MB block");
    a_read_enable_match: assert property (@(posedge pclk) disable iff (!presetn)
        !read_enable_n |-> bank_select_n != 8'hff)
        else $error("read enable without a selected bank");
    a_word_upper_lanes: assert property (@(posedge pclk) disable iff (!presetn)
        acc_active && acc_write && acc_size == CSDEC_WORD && acc_addr[1] && next_width == CSDEC_W32
        |=> lane_write_strobe_n == 4'h3)
        else $error("32-bit word lanes wrong");
    a_long_narrow_lanes: assert property (@(posedge pclk) disable iff (!presetn)
        acc_active && acc_write && acc_size != CSDEC_BYTE && acc_size != CSDEC_WORD && next_width == CSDEC_W8
        |=> lane_write_strobe_n == 4'he)
        else $error("8-bit longword lanes wrong");
    a_boot_strap_width: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(strap_done) |-> bank_control_reg[0][7:6] == $past(strap_q2[1:0]) &&
        bank_control_reg[0][8] == $past(strap_q2[2]) && bank_mask_reg[7] == 32'h0)
        else $error("boot width not taken from strap");

endmodule

/* sim/csdec_mem_model.sv */
// Far-side memory on one bank that records which lanes were strobed
`timescale 1ns/100ps
module csdec_mem_model #(
    parameter int BANK = 3
) (
    // Clock and clear
    input wire logic pclk,
    input wire logic clear,
    // Pins from the decoder
    input wire logic [7:0] bank_select_n,
    input wire logic [3:0] lane_write_strobe_n,
    // Lanes seen strobed while selected
    output logic [3:0] lane_used
);
    // A byte-wide part is wired to data bits 31:24 only, which is lane 0
    always_ff @(posedge pclk) begin
        if (clear) begin
            lane_used <= 4'h0;
        end else if (!bank_select_n[BANK]) begin
            lane_used <= lane_used | ~lane_write_strobe_n;
        end
    end
endmodule

/* sim/csdec_top_tb_top.sv */
// Self-checking bench for the chip-select decoder
`timescale 1ns/100ps
`include "csdec_consts.svh"
module csdec_top_tb_top;
    import csdec_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, clear;
    logic acc_active, acc_write, acc_cpu_space, read_enable_n, cycle_burst_ok, cycle_ext_term;
    logic cycle_auto_ack, cycle_multi_match, g_ack, g_burst, g_multi;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, acc_addr;
    csdec_size_t acc_size;
    csdec_width_t cycle_port_width;
    logic [7:0] strap_data, bank_select_n;
    logic [3:0] lane_write_strobe_n, cycle_wait_states, lane_used, g_ws;
    logic [9:0] mk [6];
    int err_total, checked;

    csdec_top csdec_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_active(acc_active), .acc_addr(acc_addr), .acc_size(acc_size),
        .acc_write(acc_write), .acc_cpu_space(acc_cpu_space), .strap_data(strap_data),
        .bank_select_n(bank_select_n), .lane_write_strobe_n(lane_write_strobe_n),
        .read_enable_n(read_enable_n), .cycle_port_width(cycle_port_width),
        .cycle_burst_ok(cycle_burst_ok), .cycle_ext_term(cycle_ext_term),
        .cycle_auto_ack(cycle_auto_ack), .cycle_wait_states(cycle_wait_states),
        .cycle_multi_match(cycle_multi_match));
    csdec_mem_model #(.BANK(3)) csdec_mem_model_inst (.pclk(pclk), .clear(clear),
        .bank_select_n(bank_select_n), .lane_write_strobe_n(lane_write_strobe_n),
        .lane_used(lane_used));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task results;
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wreg(input logic [9:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask

    task rreg(input logic [9:0] i);
        apb(1'b0, {i, 2'b00}, 32'h0);
    endtask

    // One decoded access; attributes not checked here are kept for the caller
    task acc(input logic [31:0] a, input csdec_size_t s, input logic w, input logic c,
            input logic [7:0] es, input logic [3:0] el, input csdec_width_t ew, input logic et);
        acc_active <= 1'b1;
        acc_addr <= a;
        acc_size <= s;
        acc_write <= w;
        acc_cpu_space <= c;
        @(posedge pclk);
        #1;
        chk(bank_select_n, es);
        chk(lane_write_strobe_n, el);
        chk(cycle_port_width, ew);
        chk(cycle_ext_term, et);
        g_ws = cycle_wait_states;
        g_ack = cycle_auto_ack;
        g_burst = cycle_burst_ok;
        g_multi = cycle_multi_match;
        @(negedge pclk);
        #1;
        chk(read_enable_n, w | (es == 8'hff));
        @(posedge pclk);
        acc_active <= 1'b0;
        @(posedge pclk);
        #1;
        chk(bank_select_n, 8'hff);
        @(posedge pclk);
    endtask

    function automatic csdec_width_t bwid(input int k);
        return (k == 3) ? CSDEC_W8 : (k == 4) ? CSDEC_W16 : CSDEC_W32;
    endfunction

    function automatic logic [3:0] elane(input csdec_width_t w, input csdec_size_t s, input logic a1);
        if (w == CSDEC_W8) return 4'he;
        if (w == CSDEC_W16) return 4'hc;
        if (s != CSDEC_WORD) return 4'h0;
        return a1 ? 4'h3 : 4'hc;
    endfunction

    task do_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task t_boot;
        rreg(`CSDEC_IDX_CTRL0);
        chk(rd, 32'h3da0);
        rreg(`CSDEC_IDX_MASK0);
        chk(rd, 32'h0);
        acc(32'h3000_0000, CSDEC_WORD, 1'b0, 1'b0, 8'hfe, 4'hc, CSDEC_W16, 1'b0);
        chk(g_ws, 4'hf);
        chk(g_ack, 1'b1);
        $display("Test boot done");
    endtask

    task t_regs;
        wreg(`CSDEC_IDX_MASK2, 32'hffffffff);
        rreg(`CSDEC_IDX_MASK2);
        chk(rd, 32'h1);
        chk(err, 1'b0);
        wreg(`CSDEC_IDX_MASK7, 32'hffffffff);
        rreg(`CSDEC_IDX_MASK7);
        chk(rd, 32'h101);
        wreg(`CSDEC_IDX_BASE1, 32'hffffffff);
        rreg(`CSDEC_IDX_BASE1);
        chk(rd, 32'hffff);
        wreg(`CSDEC_IDX_MASK1, 32'hffffffff);
        rreg(`CSDEC_IDX_MASK1);
        chk(rd, 32'hffff0101);
        wreg(`CSDEC_IDX_SHARED, 32'hffffffff);
        rreg(`CSDEC_IDX_SHARED);
        chk(rd, 32'hff);
        wreg(`CSDEC_IDX_CTRL2, 32'hffffffff);
        rreg(`CSDEC_IDX_CTRL2);
        chk(rd, 32'h3df8);
        wreg(10'h0a4, 32'hffffffff);
        chk(err, 1'b1);
        rreg(10'h0a4);
        chk(rd, 32'h0);
        $display("Test registers done");
    endtask

    task t_match;
        wreg(`CSDEC_IDX_BASE1, 32'h1010);
        wreg(`CSDEC_IDX_MASK1, 32'h00100001);
        wreg(`CSDEC_IDX_CTRL1, 32'h1578);
        wreg(`CSDEC_IDX_SHARED, 32'h40);
        wreg(`CSDEC_IDX_CTRL2, 32'h0);
        wreg(`CSDEC_IDX_CTRL3, 32'h40);
        wreg(`CSDEC_IDX_CTRL4, 32'h80);
        for (int i = 0; i < 6; i++) wreg(mk[i], 32'h1);
        acc(32'h1010_0000, CSDEC_WORD, 1'b0, 1'b0, 8'hfe, 4'hc, CSDEC_W16, 1'b0);
        wreg(`CSDEC_IDX_BASE0, 32'h1000);
        wreg(`CSDEC_IDX_MASK0, 32'h000f0001);
        acc(32'h1005_0000, CSDEC_WORD, 1'b0, 1'b0, 8'hfe, 4'hc, CSDEC_W16, 1'b0);
        acc(32'h1010_0000, CSDEC_WORD, 1'b0, 1'b0, 8'hfd, 4'he, CSDEC_W8, 1'b0);
        chk(g_ws, 4'h5);
        chk(g_ack, 1'b1);
        chk(g_burst, 1'b1);
        acc(32'h1000_0000, CSDEC_LONG, 1'b0, 1'b0, 8'hfc, 4'hf, CSDEC_W32, 1'b1);
        chk(g_multi, 1'b1);
        chk(g_burst, 1'b0);
        acc(32'h3000_0000, CSDEC_LONG, 1'b0, 1'b0, 8'hff, 4'hf, CSDEC_W32, 1'b1);
        chk(g_burst, 1'b0);
        for (int k = 2; k < 8; k++) begin
            acc(32'h401f_fffc + (k - 2) * 32'h20_0000, CSDEC_LONG, 1'b1, 1'b0, ~(8'h1 << k),
                elane(bwid(k), CSDEC_LONG, 1'b0), bwid(k), 1'b1);
        end
        acc(32'h40e0_0000, CSDEC_LONG, 1'b0, 1'b0, 8'hff, 4'hf, CSDEC_W32, 1'b1);
        wreg(`CSDEC_IDX_MASK7, 32'h101);
        acc(32'h0, CSDEC_LONG, 1'b0, 1'b1, 8'h7f, 4'hf, CSDEC_W32, 1'b1);
        $display("Test matching done");
    endtask

    task t_lanes;
        csdec_size_t s;
        for (int b = 2; b < 5; b++) begin
            clear <= 1'b1;
            @(posedge pclk);
            clear <= 1'b0;
            for (int i = 1; i < 4; i++) begin
                for (int a1 = 0; a1 < 2; a1++) begin
                    s = csdec_size_t'(i);
                    if (a1 == 0 || i == 1) begin
                        acc(32'h4000_0000 + (b - 2) * 32'h20_0000 + a1 * 2, s, 1'b1, 1'b0, ~(8'h1 << b),
                            elane(bwid(b), s, a1[0]), bwid(b), 1'b1);
                    end
                end
            end
            if (b == 3) chk(lane_used, 4'h1);
        end
        $display("Test lanes done");
    endtask

    initial begin
        mk = '{`CSDEC_IDX_MASK2, `CSDEC_IDX_MASK3, `CSDEC_IDX_MASK4, `CSDEC_IDX_MASK5,
            `CSDEC_IDX_MASK6, `CSDEC_IDX_MASK7};
        err_total = 0;
        checked = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, acc_active, acc_write, acc_cpu_space, clear} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        acc_addr = 32'h0;
        acc_size = CSDEC_BYTE;
        strap_data = 8'hc0;
        do_reset;
        t_boot;
        t_regs;
        t_match;
        t_lanes;
        do_reset;
        t_boot;
        results;
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(4000 * 50);
        err_total++;
        results;
    end
endmodule
